// ---- inc/pin_change_pkg.sv ----
// package for the pin change edge detector: register map, widths, bus carriers
// assumes a 32-bit avalon-mm slave with word-aligned byte addresses
package pin_change_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;

    // printed offsets are not multiples of four: they are register indices
    localparam logic [12:0] IDX_PORTA_RISE_ENABLE  = 13'h1F3D;
    localparam logic [12:0] IDX_PORTA_FALL_ENABLE  = 13'h1F3E;
    localparam logic [12:0] IDX_PORTA_CHANGE_FLAGS = 13'h1F3F;
    localparam logic [12:0] IDX_PORTB_RISE_ENABLE  = 13'h1F48;
    localparam logic [12:0] IDX_PORTB_FALL_ENABLE  = 13'h1F49;
    localparam logic [12:0] IDX_PORTB_CHANGE_FLAGS = 13'h1F4A;
    localparam logic [12:0] IDX_PORTC_RISE_ENABLE  = 13'h1F53;
    localparam logic [12:0] IDX_PORTC_FALL_ENABLE  = 13'h1F54;
    localparam logic [12:0] IDX_PORTC_CHANGE_FLAGS = 13'h1F55;
    localparam logic [12:0] IDX_CONTROL_STATUS     = 13'h1F56;

    // implemented bits per port, then the porta pins lost to the debug and reset straps
    localparam logic [7:0] PORTA_MASK       = 8'h3F;
    localparam logic [7:0] PORTB_MASK       = 8'hF0;
    localparam logic [7:0] PORTC_MASK_LARGE = 8'hFF;
    localparam logic [7:0] PORTC_MASK_SMALL = 8'h3F;
    localparam logic [7:0] DEBUG_PIN_MASK   = 8'h03;
    localparam logic [7:0] RESET_PIN_MASK   = 8'h08;

    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] FLAG_RESET   = 8'h00;

    // control/status word fields
    localparam int unsigned CTRL_IRQ_ENABLE_BIT = 0;
    localparam int unsigned STAT_SUMMARY_BIT    = 1;

    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [3:0]        byteenable;
        logic [DATA_W-1:0] writedata;
    } avalon_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] readdata;
        logic              waitrequest;
        logic [1:0]        response;
    } avalon_rsp_t;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic [7:0] rise;
        logic [7:0] fall;
    } edge_pair_t;

endpackage

// ---- logic/pin_edge_sync.sv ----
// synchroniser and edge detector for one group of port pins
// assumes pins are asynchronous to core_clk_i
`timescale 1ns/1ps
module pin_edge_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             core_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] pins_i,
    output logic      [WIDTH-1:0] rise_o,
    output logic      [WIDTH-1:0] fall_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] last_q;
    logic             primed_q;

    always_ff @(posedge core_clk_i) begin
        meta_q <= pins_i;
        sync_q <= meta_q;
    end

    // no edges reported until the history holds a real sample
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            last_q   <= '0;
            primed_q <= 1'b0;
        end else begin
            last_q   <= sync_q;
            primed_q <= 1'b1;
        end
    end

    always_comb begin
        rise_o = primed_q ? (sync_q & ~last_q) : '0;
        fall_o = primed_q ? (~sync_q & last_q) : '0;
    end
endmodule // pin_edge_sync

// ---- logic/pin_change_edge_detect.sv ----
// pin change edge detector for ports a, b and c with avalon-mm register access
// assumes core_clk_i 25 MHz, reset_n_i synchronous; pins asynchronous
`timescale 1ns/1ps
module pin_change_edge_detect #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input  wire logic                       core_clk_i,
    input  wire logic                       reset_n_i,
    input  wire pin_change_pkg::avalon_req_t bus_req_i,
    output pin_change_pkg::avalon_rsp_t      bus_rsp_o,
    input  wire logic [7:0]                 porta_pin_i,
    input  wire logic [7:0]                 portb_pin_i,
    input  wire logic [7:0]                 portc_pin_i,
    input  wire logic                       debugger_enable_i,
    input  wire logic                       reset_pin_enable_i,
    input  wire logic                       low_voltage_programming_i,
    input  wire logic                       sleep_i,
    output logic                            change_irq_summary_o,
    output logic                            change_irq_o,
    output logic                            wake_o
);
    import pin_change_pkg::*;

    localparam logic [7:0] PORTB_IMPL = LARGE_VARIANT ? PORTB_MASK : 8'h00;
    localparam logic [7:0] PORTC_IMPL = LARGE_VARIANT ? PORTC_MASK_LARGE : PORTC_MASK_SMALL;

    logic [7:0] porta_rise_enable_q;
    logic [7:0] porta_fall_enable_q;
    logic [7:0] porta_change_flags_q;
    logic [7:0] portb_rise_enable_q;
    logic [7:0] portb_fall_enable_q;
    logic [7:0] portb_change_flags_q;
    logic [7:0] portc_rise_enable_q;
    logic [7:0] portc_fall_enable_q;
    logic [7:0] portc_change_flags_q;
    logic       change_irq_enable_q;
    logic [2:0] cfg_meta_q;
    logic [2:0] cfg_sync_q;
    logic [7:0] porta_avail;
    logic [7:0] porta_rise;
    logic [7:0] porta_fall;
    logic [7:0] portb_rise;
    logic [7:0] portb_fall;
    logic [7:0] portc_rise;
    logic [7:0] portc_fall;
    logic [7:0] porta_hit;
    logic [7:0] portb_hit;
    logic [7:0] portc_hit;
    logic       access_q;
    logic       summary_d;
    logic [12:0] index;
    logic       hit_known;
    logic       wr_go;
    logic [7:0] wr_byte;
    logic [DATA_W-1:0] rd_data;

    function automatic logic [7:0] edge_hits(input logic [7:0] rise, input logic [7:0] fall,
                                             input logic [7:0] ren, input logic [7:0] fen,
                                             input logic [7:0] avail);
        edge_hits = ((rise & ren) | (fall & fen)) & avail;
    endfunction

    function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] hit,
                                             input logic wr, input logic [7:0] data,
                                             input logic [7:0] avail);
        logic [7:0] kept;
        kept = wr ? (data & cur) : cur;
        flag_next = (kept | hit) & avail;
    endfunction

    pin_edge_sync #(.WIDTH(8)) u_porta_sync (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .pins_i     (porta_pin_i),
        .rise_o     (porta_rise),
        .fall_o     (porta_fall)
    );
    pin_edge_sync #(.WIDTH(8)) u_portb_sync (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .pins_i     (portb_pin_i),
        .rise_o     (portb_rise),
        .fall_o     (portb_fall)
    );
    pin_edge_sync #(.WIDTH(8)) u_portc_sync (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .pins_i     (portc_pin_i),
        .rise_o     (portc_rise),
        .fall_o     (portc_fall)
    );

    // configuration straps come from another domain
    always_ff @(posedge core_clk_i) begin
        cfg_meta_q <= {debugger_enable_i, reset_pin_enable_i, low_voltage_programming_i};
        cfg_sync_q <= cfg_meta_q;
    end

    always_comb begin
        porta_avail = PORTA_MASK;
        if (cfg_sync_q[2]) begin
            porta_avail = porta_avail & ~DEBUG_PIN_MASK;
        end
        if (cfg_sync_q[1] || cfg_sync_q[0]) begin
            porta_avail = porta_avail & ~RESET_PIN_MASK;
        end
    end

    always_comb begin
        porta_hit = edge_hits(porta_rise, porta_fall, porta_rise_enable_q, porta_fall_enable_q, porta_avail);
        portb_hit = edge_hits(portb_rise, portb_fall, portb_rise_enable_q, portb_fall_enable_q, PORTB_IMPL);
        portc_hit = edge_hits(portc_rise, portc_fall, portc_rise_enable_q, portc_fall_enable_q, PORTC_IMPL);
    end

    // bus decode: one wait state, answer on the second edge
    always_comb begin
        index     = bus_req_i.address[14:2];
        wr_go     = access_q && bus_req_i.write && bus_req_i.byteenable[0];
        wr_byte   = bus_req_i.writedata[7:0];
        hit_known = 1'b1;
        rd_data   = UNMAPPED_READ;
        unique case (index)
            IDX_PORTA_RISE_ENABLE:  rd_data[7:0] = porta_rise_enable_q;
            IDX_PORTA_FALL_ENABLE:  rd_data[7:0] = porta_fall_enable_q;
            IDX_PORTA_CHANGE_FLAGS: rd_data[7:0] = porta_change_flags_q;
            IDX_PORTB_RISE_ENABLE:  rd_data[7:0] = portb_rise_enable_q;
            IDX_PORTB_FALL_ENABLE:  rd_data[7:0] = portb_fall_enable_q;
            IDX_PORTB_CHANGE_FLAGS: rd_data[7:0] = portb_change_flags_q;
            IDX_PORTC_RISE_ENABLE:  rd_data[7:0] = portc_rise_enable_q;
            IDX_PORTC_FALL_ENABLE:  rd_data[7:0] = portc_fall_enable_q;
            IDX_PORTC_CHANGE_FLAGS: rd_data[7:0] = portc_change_flags_q;
            IDX_CONTROL_STATUS: begin
                rd_data[CTRL_IRQ_ENABLE_BIT] = change_irq_enable_q;
                rd_data[STAT_SUMMARY_BIT]    = change_irq_summary_o;
            end
            default:                hit_known = 1'b0;
        endcase
        if (!LARGE_VARIANT && (index == IDX_PORTB_RISE_ENABLE || index == IDX_PORTB_FALL_ENABLE
                               || index == IDX_PORTB_CHANGE_FLAGS)) begin
            hit_known = 1'b0;
            rd_data   = UNMAPPED_READ;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            access_q  <= 1'b0;
            bus_rsp_o <= '{readdata: UNMAPPED_READ, waitrequest: 1'b1, response: RESP_OKAY};
        end else begin
            access_q              <= (bus_req_i.read || bus_req_i.write) && !access_q;
            bus_rsp_o.waitrequest <= !((bus_req_i.read || bus_req_i.write) && !access_q);
            bus_rsp_o.readdata    <= rd_data;
            bus_rsp_o.response    <= hit_known ? RESP_OKAY : RESP_DECERR;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            porta_rise_enable_q <= ENABLE_RESET;
            porta_fall_enable_q <= ENABLE_RESET;
            portb_rise_enable_q <= ENABLE_RESET;
            portb_fall_enable_q <= ENABLE_RESET;
            portc_rise_enable_q <= ENABLE_RESET;
            portc_fall_enable_q <= ENABLE_RESET;
            change_irq_enable_q <= 1'b0;
        end else if (wr_go && hit_known) begin
            unique case (index)
                IDX_PORTA_RISE_ENABLE: porta_rise_enable_q <= wr_byte & PORTA_MASK;
                IDX_PORTA_FALL_ENABLE: porta_fall_enable_q <= wr_byte & PORTA_MASK;
                IDX_PORTB_RISE_ENABLE: portb_rise_enable_q <= wr_byte & PORTB_IMPL;
                IDX_PORTB_FALL_ENABLE: portb_fall_enable_q <= wr_byte & PORTB_IMPL;
                IDX_PORTC_RISE_ENABLE: portc_rise_enable_q <= wr_byte & PORTC_IMPL;
                IDX_PORTC_FALL_ENABLE: portc_fall_enable_q <= wr_byte & PORTC_IMPL;
                IDX_CONTROL_STATUS:    change_irq_enable_q <= wr_byte[CTRL_IRQ_ENABLE_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            porta_change_flags_q <= FLAG_RESET;
            portb_change_flags_q <= FLAG_RESET;
            portc_change_flags_q <= FLAG_RESET;
        end else begin
            porta_change_flags_q <= flag_next(porta_change_flags_q, porta_hit,
                                              wr_go && index == IDX_PORTA_CHANGE_FLAGS, wr_byte, porta_avail);
            portb_change_flags_q <= flag_next(portb_change_flags_q, portb_hit,
                                              wr_go && index == IDX_PORTB_CHANGE_FLAGS, wr_byte, PORTB_IMPL);
            portc_change_flags_q <= flag_next(portc_change_flags_q, portc_hit,
                                              wr_go && index == IDX_PORTC_CHANGE_FLAGS, wr_byte, PORTC_IMPL);
        end
    end

    always_comb begin
        summary_d = |{porta_change_flags_q, portb_change_flags_q, portc_change_flags_q};
    end

    // irq and wake gated only here
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            change_irq_summary_o <= 1'b0;
            change_irq_o         <= 1'b0;
            wake_o               <= 1'b0;
        end else begin
            change_irq_summary_o <= summary_d;
            change_irq_o         <= summary_d && change_irq_enable_q;
            wake_o               <= summary_d && change_irq_enable_q && sleep_i;
        end
    end
endmodule // pin_change_edge_detect

// ---- verification/pin_change_edge_detect_properties.sv ----
// port-level checks for the pin change detector
// assumes the design package is compiled first; attached by bind
`timescale 1ns/1ps
module pin_change_edge_detect_properties
    import pin_change_pkg::*;
(
    input wire logic                        core_clk_i,
    input wire logic                        reset_n_i,
    input wire pin_change_pkg::avalon_req_t bus_req_i,
    input wire pin_change_pkg::avalon_rsp_t bus_rsp_o,
    input wire logic [7:0]                  porta_pin_i,
    input wire logic [7:0]                  portb_pin_i,
    input wire logic [7:0]                  portc_pin_i,
    input wire logic                        sleep_i,
    input wire logic                        change_irq_summary_o,
    input wire logic                        change_irq_o,
    input wire logic                        wake_o
);
    logic [23:0] pins_q;
    logic [3:0]  age_q;
    logic        busy;
    logic        ans;
    assign busy = bus_req_i.read | bus_req_i.write;
    assign ans  = ~bus_rsp_o.waitrequest;
    // cycles since any pin moved, saturating
    always_ff @(posedge core_clk_i) begin
        pins_q <= {portc_pin_i, portb_pin_i, porta_pin_i};
        if (!reset_n_i) begin
            age_q <= 4'hF;
        end else if (pins_q != {portc_pin_i, portb_pin_i, porta_pin_i}) begin
            age_q <= 4'h0;
        end else if (age_q != 4'hF) begin
            age_q <= age_q + 4'h1;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    chk_wait_one: assert property (busy && !ans |=> ans)
        else $error("no answer after one wait state");
    chk_ans_short: assert property (ans |=> !ans)
        else $error("answer held too long");
    chk_ans_held: assert property (ans |-> busy)
        else $error("answer without request");
    chk_upper_zero: assert property (ans && bus_req_i.read |-> bus_rsp_o.readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_decerr_zero: assert property (ans && bus_rsp_o.response == RESP_DECERR |-> bus_rsp_o.readdata == UNMAPPED_READ)
        else $error("unmapped read not zero");
    // summary trails the flag register by one edge, so the clearing write is two edges back
    chk_flag_sticky: assert property ($fell(change_irq_summary_o) |-> $past(bus_req_i.write && ans, 2))
        else $error("flag cleared without write");
    chk_flag_cause: assert property ($rose(change_irq_summary_o) |-> age_q < 4'h8)
        else $error("flag set without pin edge");
    chk_irq_gated: assert property (change_irq_o |-> change_irq_summary_o)
        else $error("irq without summary");
    chk_wake_sleep: assert property (wake_o |-> change_irq_o && $past(sleep_i))
        else $error("wake without sleep and irq");
    cov_write: cover property (bus_req_i.write && ans);
    cov_flag: cover property ($rose(change_irq_summary_o));
    cov_wake: cover property (wake_o);
endmodule // pin_change_edge_detect_properties

bind pin_change_edge_detect pin_change_edge_detect_properties i_pin_change_edge_detect_properties (
    .core_clk_i, .reset_n_i, .bus_req_i, .bus_rsp_o, .porta_pin_i, .portb_pin_i, .portc_pin_i,
    .sleep_i, .change_irq_summary_o, .change_irq_o, .wake_o);

// ---- verification/pin_drive_model.sv ----
// far side of the detector: the three port pin groups
// assumes target_i changes just after a clock edge
`timescale 1ns/1ps
module pin_drive_model (
    input  wire logic [23:0] target_i,
    input  wire logic        core_clk_i,
    input  wire logic        slow_i,
    output logic [7:0]       porta_pin_o,
    output logic [7:0]       portb_pin_o,
    output logic [7:0]       portc_pin_o
);
    logic [23:0] near_q;
    logic [23:0] far_q [2];
    // slow pins settle two cycles late, like a loaded trace
    always_ff @(posedge core_clk_i) begin
        near_q   <= target_i;
        far_q[0] <= near_q;
        far_q[1] <= far_q[0];
    end
    assign {portc_pin_o, portb_pin_o, porta_pin_o} = slow_i ? far_q[1] : near_q;
endmodule // pin_drive_model

// ---- verification/pin_change_edge_detect_tb_top.sv ----
// self-checking bench for the pin change detector
// assumes package, pin model and checker compiled first
`timescale 1ns/1ps
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin failures++; \
    $display("BAD %0t got %h want %h", $time, act, exp); end end
module pin_change_edge_detect_tb_top;
    import pin_change_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    avalon_req_t bus_req = '0;
    avalon_rsp_t bus_rsp;
    logic [23:0] target = '0;
    logic        slow = 1'b0, dbg = 1'b0, rpe = 1'b0, low_voltage_programming = 1'b0, sleep = 1'b0, irq_en;
    logic [7:0]  pa, pb, pc;
    logic        summary, irq, wake;
    logic [33:0] exp_q [$];
    logic [33:0] exp_v;
    logic [7:0]  p [3], n [3], m [3], fx [3];
    logic [12:0] base [3] = '{IDX_PORTA_RISE_ENABLE, IDX_PORTB_RISE_ENABLE, IDX_PORTC_RISE_ENABLE};
    logic [7:0]  full [3] = '{PORTA_MASK, PORTB_MASK, PORTC_MASK_LARGE};
    logic [23:0] a, b;
    logic [31:0] r;
    integer      seed = 32'hCB75;
    int          failures = 0, cmp_count = 0, cyc = 0;

    always #20 core_clk_i = ~core_clk_i;
    pin_drive_model i_pin_drive_model (.target_i(target), .core_clk_i(core_clk_i), .slow_i(slow),
        .porta_pin_o(pa), .portb_pin_o(pb), .portc_pin_o(pc));
    pin_change_edge_detect i_pin_change_edge_detect (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .bus_req_i(bus_req), .bus_rsp_o(bus_rsp), .porta_pin_i(pa), .portb_pin_i(pb), .portc_pin_i(pc),
        .debugger_enable_i(dbg), .reset_pin_enable_i(rpe), .low_voltage_programming_i(low_voltage_programming),
        .sleep_i(sleep), .change_irq_summary_o(summary), .change_irq_o(irq), .wake_o(wake));

    task automatic end_of_test();
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic hop(input int k);
        repeat (k) @(posedge core_clk_i);
    endtask
    // one bus transfer; a spare edge keeps raises off the release edge
    task automatic acc(input logic [12:0] idx, input logic wr, input logic [7:0] d);
        bus_req.address <= {1'b0, idx, 2'b00};
        bus_req.read <= ~wr;
        bus_req.write <= wr;
        bus_req.byteenable <= 4'hF;
        bus_req.writedata <= {24'h0, d};
        do @(posedge core_clk_i); while (bus_rsp.waitrequest !== 1'b0);
        bus_req.read <= 1'b0;
        bus_req.write <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic rd(input logic [12:0] idx, input logic [7:0] e);
        exp_q.push_back({RESP_OKAY, 24'h0, e});
        acc(idx, 1'b0, 8'h00);
    endtask

    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (bus_req.read && bus_rsp.waitrequest === 1'b0) begin
            exp_v = exp_q.pop_front();
            `CHK({bus_rsp.response, bus_rsp.readdata}, exp_v)
        end
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end

    initial begin
        hop(20);
        reset_n_i <= 1'b1;
        @(posedge core_clk_i);
        for (int i = 0; i < 9; i++) begin
            rd(base[i / 3] + 13'(i % 3), 8'h00);
        end
        rd(IDX_CONTROL_STATUS, 8'h00);
        exp_q.push_back({RESP_DECERR, UNMAPPED_READ});
        acc(13'h1F40, 1'b1, 8'hFF);
        acc(13'h1F40, 1'b0, 8'h00);
        for (int k = 0; k < 12; k++) begin
            r = $random(seed);
            a = 24'($random(seed));
            b = 24'($random(seed));
            irq_en = r[5];
            target <= a;
            acc(IDX_CONTROL_STATUS, 1'b1, {7'h0, irq_en});
            for (int i = 0; i < 3; i++) begin
                p[i] = 8'($random(seed));
                n[i] = 8'($random(seed));
                m[i] = full[i];
                acc(base[i], 1'b1, p[i]);
                acc(base[i] + 13'd1, 1'b1, n[i]);
                acc(base[i] + 13'd2, 1'b1, 8'h00);
            end
            // straps move only once the old flags are cleared, so masking never drops a flag
            {dbg, rpe, low_voltage_programming, sleep, slow} <= r[4:0];
            m[0] = PORTA_MASK & ~(r[4] ? DEBUG_PIN_MASK : 8'h00) & ~((r[3] | r[2]) ? RESET_PIN_MASK : 8'h00);
            target <= b;
            hop(12);
            for (int i = 0; i < 3; i++) begin
                fx[i] = ((~a[8*i +: 8] & b[8*i +: 8] & p[i]) | (a[8*i +: 8] & ~b[8*i +: 8] & n[i])) & m[i];
                rd(base[i] + 13'd2, fx[i]);
                rd(base[i], p[i] & full[i]);
                rd(base[i] + 13'd1, n[i] & full[i]);
            end
            rd(IDX_CONTROL_STATUS, {6'h0, |{fx[0], fx[1], fx[2]}, irq_en});
            `CHK(irq, irq_en & |{fx[0], fx[1], fx[2]})
            `CHK(wake, sleep & irq_en & |{fx[0], fx[1], fx[2]})
        end
        slow <= 1'b0;
        acc(base[2], 1'b1, 8'h01);
        acc(base[2] + 13'd1, 1'b1, 8'h01);
        // sweep the clear across the edge's arrival cycle
        for (int d = 0; d < 6; d++) begin
            target <= target ^ 24'h01_0000;
            hop(d);
            acc(base[2] + 13'd2, 1'b1, 8'h00);
            hop(8);
            // edge lands four edges after the pin move; a clear taking effect later wins
            rd(base[2] + 13'd2, (d <= 2) ? 8'h01 : 8'h00);
        end
        acc(base[2] + 13'd2, 1'b1, 8'h00);
        rd(base[2] + 13'd2, 8'h00);
        end_of_test();
    end
endmodule // pin_change_edge_detect_tb_top
